// ---- mbc_checker.sv ----
`timescale 1ns/1ps
module mbc_checker import mbc_pkg::*; #(
	parameter int test_addr_width_param = 10
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// memory test master
	input wire logic test_req_out,
	input wire logic test_we_out,
	input wire logic [test_addr_width_param-1:0] test_address_out,
	// system side
	input wire logic func_block_out,
	input wire logic irq_out
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// bus steps: request taken, then a single-cycle answer
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	// memory steps: read, check cycle, write back at the same entry
	sequence s_rd;
		test_req_out && !test_we_out;
	endsequence
	sequence s_rd_then_wr;
		s_rd ##1 !test_req_out ##1 (test_req_out && test_we_out);
	endsequence

	AST_WB_ANSWER: assert property (s_take |=> s_ack_pulse)
		else $error("bus answer not a single pulse one cycle after request");
	AST_WB_NO_STRAY_ACK: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without a request");
	AST_WB_DATA_IDLE: assert property (!wb_ack_o |-> wb_dat_o == '0)
		else $error("read data not zero outside ack");
	AST_RD_GAP: assert property (s_rd |=> !test_req_out ##1 !(test_req_out && !test_we_out))
		else $error("read not followed by its check cycle");
	AST_RD_ADDR_HOLD: assert property (s_rd |=> $stable(test_address_out))
		else $error("address moved during read check");
	AST_WR_SAME_ENTRY: assert property (s_rd_then_wr |-> test_address_out == $past(test_address_out, 2))
		else $error("write back at another entry than the read");
	AST_REQ_BLOCKED: assert property (test_req_out |-> func_block_out)
		else $error("test transaction while functional path open");
	AST_REQ_SPACED: assert property (test_req_out |=> !test_req_out)
		else $error("two transactions back to back");
	AST_IRQ_CLEAR_BY_WRITE: assert property ($fell(irq_out) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o))
		else $error("interrupt dropped without a register write");
endmodule : mbc_checker

bind mbc_top mbc_checker #(.test_addr_width_param(test_addr_width_param)) i_chk (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.test_req_out(test_req_out),
	.test_we_out(test_we_out),
	.test_address_out(test_address_out),
	.func_block_out(func_block_out),
	.irq_out(irq_out)
);

// ---- mbc_exec.sv ----
`timescale 1ns/1ps
module mbc_exec import mbc_pkg::*; #(
	parameter int AW = 10,
	parameter int DW = 32,
	parameter int PROG = 6
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// control
	input wire logic start,
	input wire logic stop_on_err,
	input wire logic [AW-1:0] low_addr,
	input wire logic [AW-1:0] high_addr,
	input wire logic [DW-1:0] bg,
	// result
	output logic busy,
	output logic done_pulse,
	output logic err_pulse,
	output logic [AW-1:0] fail_addr,
	// memory side
	output logic mem_req,
	output logic mem_we,
	output logic [AW-1:0] mem_addr,
	output logic [DW-1:0] mem_wdata,
	input wire logic [DW-1:0] mem_rdata
);
	typedef enum logic [2:0] {
		MBC_IDLE = 3'h0,
		MBC_READ = 3'h1,
		MBC_CHECK = 3'h3,
		MBC_WRITE = 3'h2,
		MBC_STEP = 3'h6
	} mbc_state_e;

	mbc_state_e state_reg, state_next;
	logic [2:0] elem_reg, elem_next;
	logic [AW-1:0] addr_reg, addr_next;
	logic [AW-1:0] fail_reg, fail_next;
	logic done_reg, done_next;
	logic err_reg, err_next;
	mbc_elem_s cur, nxt, first_el;
	logic last_addr;
	logic miss;

	assign cur = mbc_elem(elem_reg);
	assign nxt = mbc_elem(elem_reg + 3'h1);
	assign first_el = mbc_elem(3'h0);
	assign last_addr = cur.down ? (addr_reg == low_addr) : (addr_reg == high_addr);
	assign miss = mem_rdata != (cur.rval ? ~bg : bg);

	// march sequencer: every entry of every element is visited, unless stop_on_err ends the run at the first miss
	always_comb begin
		state_next = state_reg;
		elem_next = elem_reg;
		addr_next = addr_reg;
		fail_next = fail_reg;
		done_next = 1'b0;
		err_next = 1'b0;
		unique case (state_reg)
			MBC_IDLE: begin
				if (start) begin
					elem_next = 3'h0;
					addr_next = first_el.down ? high_addr : low_addr;
					state_next = first_el.rd ? MBC_READ : MBC_WRITE;
				end
			end
			MBC_READ: state_next = MBC_CHECK;
			MBC_CHECK: begin
				if (miss) begin
					err_next = 1'b1;
					fail_next = addr_reg;
				end
				if (miss && stop_on_err) begin
					done_next = 1'b1;
					state_next = MBC_IDLE;
				end else begin
					state_next = cur.wr ? MBC_WRITE : MBC_STEP;
				end
			end
			MBC_WRITE: state_next = MBC_STEP;
			MBC_STEP: begin
				if (!last_addr) begin
					addr_next = cur.down ? addr_reg - 1'b1 : addr_reg + 1'b1;
					state_next = cur.rd ? MBC_READ : MBC_WRITE;
				end else if (32'(elem_reg) + 1 >= PROG) begin
					done_next = 1'b1;
					state_next = MBC_IDLE;
				end else begin
					elem_next = elem_reg + 3'h1;
					addr_next = nxt.down ? high_addr : low_addr;
					state_next = nxt.rd ? MBC_READ : MBC_WRITE;
				end
			end
			default: state_next = MBC_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= MBC_IDLE;
			elem_reg <= 3'h0;
			addr_reg <= '0;
			fail_reg <= '0;
			done_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			elem_reg <= elem_next;
			addr_reg <= addr_next;
			fail_reg <= fail_next;
			done_reg <= done_next;
			err_reg <= err_next;
		end
	end

	assign busy = state_reg != MBC_IDLE;
	assign done_pulse = done_reg;
	assign err_pulse = err_reg;
	assign fail_addr = fail_reg;
	assign mem_req = (state_reg == MBC_READ) || (state_reg == MBC_WRITE);
	assign mem_we = state_reg == MBC_WRITE;
	assign mem_addr = addr_reg;
	assign mem_wdata = cur.wval ? ~bg : bg;

endmodule : mbc_exec

// ---- mbc_mem_model.sv ----
`timescale 1ns/1ps
module mbc_mem_model #(
	parameter int AW = 4,
	parameter int DW = 8
) (
	// clock
	input wire logic clk_sys,
	// test master side
	input wire logic test_req_out,
	input wire logic test_we_out,
	input wire logic [AW-1:0] test_address_out,
	input wire logic [DW-1:0] test_write_data_out,
	output logic [DW-1:0] test_read_data_in,
	// fault injection, bit 0 flips on reads of one entry
	input wire logic fault_en,
	input wire logic [AW-1:0] fault_addr
);
	logic [DW-1:0] mem [2**AW];
	int wr_cnt [2**AW];

	initial begin
		test_read_data_in = '0;
		foreach (wr_cnt[i]) wr_cnt[i] = 0;
	end

	// one-cycle read latency; data is only valid that cycle, so it toggles after
	always @(posedge clk_sys) begin
		if (test_req_out && test_we_out) begin
			mem[test_address_out] <= test_write_data_out;
			wr_cnt[test_address_out] <= wr_cnt[test_address_out] + 1;
		end
		if (test_req_out && !test_we_out)
			test_read_data_in <= mem[test_address_out] ^ DW'(fault_en && test_address_out == fault_addr);
		else
			test_read_data_in <= ~test_read_data_in;
	end
endmodule : mbc_mem_model

// ---- mbc_par_reg.sv ----
`timescale 1ns/1ps
module mbc_par_reg import mbc_pkg::*; #(
	parameter int W = 8,
	parameter bit RESET_ALL = 1'b1,
	parameter bit REQUIRED = 1'b1,
	parameter bit PARITY = 1'b0,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// load port
	input wire logic we,
	input wire logic [W-1:0] d,
	// stored value
	output logic [W-1:0] q,
	output logic par_err
);
	logic [W-1:0] q_next;
	logic par_reg;
	logic par_next;

	// hold unless loaded; parity follows the value
	always_comb begin
		q_next = we ? d : q;
		par_next = ^q_next;
	end

	// reset scope chosen at build time
	generate
		if (RESET_ALL || REQUIRED) begin : g_rst
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					q <= RST_VAL;
					par_reg <= ^RST_VAL;
				end else begin
					q <= q_next;
					par_reg <= par_next;
				end
			end
		end else begin : g_norst
			// saves reset routing on wide data flops
			always_ff @(posedge clk_sys) begin
				q <= q_next;
				par_reg <= par_next;
			end
		end
	endgenerate

	assign par_err = PARITY ? (par_reg != ^q) : 1'b0;

endmodule : mbc_par_reg

// ---- mbc_pkg.sv ----
package mbc_pkg;

	// register byte offsets inside the 4 KB window
	localparam logic [11:0] MBC_CTRL_OFS = 12'h000;
	localparam logic [11:0] MBC_STAT_OFS = 12'h004;
	localparam logic [11:0] MBC_MASK_OFS = 12'h008;
	localparam logic [11:0] MBC_LOW_OFS = 12'h00C;
	localparam logic [11:0] MBC_HIGH_OFS = 12'h010;
	localparam logic [11:0] MBC_ARR_OFS = 12'h014;
	localparam logic [11:0] MBC_BG_OFS = 12'h018;
	localparam logic [11:0] MBC_FAIL_OFS = 12'h01C;
	localparam logic [11:0] MBC_MERR_OFS = 12'h020;
	localparam logic [11:0] MBC_CFG0_OFS = 12'h024;
	localparam logic [11:0] MBC_CFG1_OFS = 12'h028;
	localparam int MBC_WIN_BITS = 12;

	// control fields
	localparam int MBC_CTRL_START = 0;
	localparam int MBC_CTRL_OFFL = 1;
	localparam int MBC_CTRL_STOP = 2;
	// status / mask fields
	localparam int MBC_ST_DONE = 0;
	localparam int MBC_ST_ERR = 1;
	localparam int MBC_ST_PAR = 2;
	localparam int MBC_ST_BITS = 3;
	localparam int MBC_ST_BUSY = 8;

	// reset values
	localparam logic [2:0] MBC_CTRL_RST = 3'h0;
	localparam logic [2:0] MBC_MASK_RST = 3'h0;
	localparam int MBC_PLU_BITS = 2;

	// one march element
	typedef struct packed {
		logic down;
		logic rd;
		logic rval;
		logic wr;
		logic wval;
	} mbc_elem_s;

	// march c-: up w0; up r0w1; up r1w0; down r0w1; down r1w0; up r0
	function automatic mbc_elem_s mbc_elem(input logic [2:0] idx);
		unique case (idx)
			3'h0: mbc_elem = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
			3'h1: mbc_elem = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
			3'h2: mbc_elem = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
			3'h3: mbc_elem = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
			3'h4: mbc_elem = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
			default: mbc_elem = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
		endcase
	endfunction : mbc_elem

endpackage : mbc_pkg

// ---- mbc_top.sv ----
`timescale 1ns/1ps
module mbc_top import mbc_pkg::*; #(
	parameter bit reset_scope_param = 1'b1,
	parameter bit flop_parity_param = 1'b0,
	parameter int test_addr_width_param = 10,
	parameter int test_data_width_param = 32,
	parameter int array_select_width_param = 6,
	parameter int error_input_width_param = 4,
	parameter int program_size_param = 6
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// memory test master
	output logic test_req_out,
	output logic test_we_out,
	output logic [test_addr_width_param-1:0] test_address_out,
	output logic [test_data_width_param-1:0] test_write_data_out,
	input wire logic [test_data_width_param-1:0] test_read_data_in,
	output logic [array_select_width_param-1:0] array_select_out,
	input wire logic [error_input_width_param-1:0] memory_error_in,
	// system side
	output logic func_block_out,
	output logic irq_out
);
	localparam int AW = test_addr_width_param;
	localparam int DW = test_data_width_param;
	localparam int ARW = array_select_width_param;
	localparam int ERW = error_input_width_param;
	localparam int ASW = ARW - MBC_PLU_BITS;

	// bus decode
	logic req;
	logic wr;
	logic [MBC_WIN_BITS-1:0] ofs;
	logic ack_reg, ack_next;
	logic [31:0] rdat_reg, rdat_next;

	// register store
	logic [2:0] ctrl_reg, ctrl_next;
	logic [MBC_ST_BITS-1:0] stat_reg, stat_next;
	logic [MBC_ST_BITS-1:0] mask_q;
	logic [AW-1:0] low_q, high_q;
	logic [ARW-1:0] arr_q;
	logic [DW-1:0] bg_q;
	logic [ERW-1:0] merr_reg, merr_next;
	logic start_reg, start_next;
	logic [4:0] wen;
	logic [4:0] perr;
	logic [31:0] mask_m, low_m, high_m, arr_m, bg_m;

	// execution unit result
	logic busy;
	logic done_pulse;
	logic err_pulse;
	logic [AW-1:0] fail_addr;
	logic mem_req;
	logic mem_we;
	logic [AW-1:0] mem_addr;
	logic [DW-1:0] mem_wdata;

	// byte-lane merge for partial writes
	function automatic logic [31:0] mbc_merge(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		mbc_merge = res;
	endfunction : mbc_merge

	// one access per request, address wraps inside the window
	assign req = wb_cyc_i && wb_stb_i && !ack_reg;
	assign wr = req && wb_we_i;
	assign ofs = wb_adr_i[MBC_WIN_BITS-1:0];

	// merged write words; slices are taken from these, never from a call
	assign mask_m = mbc_merge(32'(mask_q), wb_dat_i, wb_sel_i);
	assign low_m = mbc_merge(32'(low_q), wb_dat_i, wb_sel_i);
	assign high_m = mbc_merge(32'(high_q), wb_dat_i, wb_sel_i);
	assign arr_m = mbc_merge(32'(arr_q), wb_dat_i, wb_sel_i);
	assign bg_m = mbc_merge(32'(bg_q), wb_dat_i, wb_sel_i);

	// load strobes of the parity-protected registers
	always_comb begin
		wen = 5'h0;
		if (wr) begin
			wen[0] = ofs == MBC_MASK_OFS;
			wen[1] = ofs == MBC_LOW_OFS;
			wen[2] = ofs == MBC_HIGH_OFS;
			wen[3] = ofs == MBC_ARR_OFS;
			wen[4] = ofs == MBC_BG_OFS;
		end
	end

	// mask register: per-event choice between interrupt and flag
	mbc_par_reg #(
		.W(MBC_ST_BITS),
		.RESET_ALL(reset_scope_param),
		.REQUIRED(1'b1),
		.PARITY(flop_parity_param),
		.RST_VAL(MBC_MASK_RST)
	) u_mask (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.we(wen[0]),
		.d(mask_m[MBC_ST_BITS-1:0]),
		.q(mask_q),
		.par_err(perr[0])
	);

	// address bounds of the march
	mbc_par_reg #(
		.W(AW),
		.RESET_ALL(reset_scope_param),
		.REQUIRED(1'b0),
		.PARITY(flop_parity_param),
		.RST_VAL('0)
	) u_low (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.we(wen[1]),
		.d(low_m[AW-1:0]),
		.q(low_q),
		.par_err(perr[1])
	);

	mbc_par_reg #(
		.W(AW),
		.RESET_ALL(reset_scope_param),
		.REQUIRED(1'b0),
		.PARITY(flop_parity_param),
		.RST_VAL('1)
	) u_high (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.we(wen[2]),
		.d(high_m[AW-1:0]),
		.q(high_q),
		.par_err(perr[2])
	);

	// array select, upper two bits are the protection unit field
	mbc_par_reg #(
		.W(ARW),
		.RESET_ALL(reset_scope_param),
		.REQUIRED(1'b0),
		.PARITY(flop_parity_param),
		.RST_VAL('0)
	) u_arr (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.we(wen[3]),
		.d(arr_m[ARW-1:0]),
		.q(arr_q),
		.par_err(perr[3])
	);

	// data background pattern
	mbc_par_reg #(
		.W(DW),
		.RESET_ALL(reset_scope_param),
		.REQUIRED(1'b0),
		.PARITY(flop_parity_param),
		.RST_VAL('0)
	) u_bg (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.we(wen[4]),
		.d(bg_m[DW-1:0]),
		.q(bg_q),
		.par_err(perr[4])
	);

	// execution unit: the bus reaches it only through the stored registers and the registered start
	mbc_exec #(
		.AW(AW),
		.DW(DW),
		.PROG(program_size_param)
	) u_exec (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.start(start_reg),
		.stop_on_err(ctrl_reg[MBC_CTRL_STOP]),
		.low_addr(low_q),
		.high_addr(high_q),
		.bg(bg_q),
		.busy(busy),
		.done_pulse(done_pulse),
		.err_pulse(err_pulse),
		.fail_addr(fail_addr),
		.mem_req(mem_req),
		.mem_we(mem_we),
		.mem_addr(mem_addr),
		.mem_wdata(mem_wdata),
		.mem_rdata(test_read_data_in)
	);

	// control, sticky status and error capture
	always_comb begin
		ctrl_next = ctrl_reg;
		start_next = 1'b0;
		stat_next = stat_reg;
		merr_next = merr_reg;
		if (wr && ofs == MBC_CTRL_OFS && wb_sel_i[0]) begin
			ctrl_next = wb_dat_i[2:0] & 3'h6; // start bit never stored
			start_next = wb_dat_i[MBC_CTRL_START] && !busy;
		end
		// write one to clear, applied before the sets
		if (wr && ofs == MBC_STAT_OFS && wb_sel_i[0]) begin
			stat_next = stat_reg & ~wb_dat_i[MBC_ST_BITS-1:0];
		end
		if (wr && ofs == MBC_MERR_OFS) begin
			merr_next = '0;
		end
		// a set in the clearing cycle wins, so no event is lost
		if (done_pulse) begin
			stat_next[MBC_ST_DONE] = 1'b1;
		end
		if (err_pulse) begin
			stat_next[MBC_ST_ERR] = 1'b1;
		end
		if (busy && |memory_error_in) begin
			merr_next = merr_next | memory_error_in;
			stat_next[MBC_ST_ERR] = 1'b1;
		end
		if (|perr) begin
			stat_next[MBC_ST_PAR] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= MBC_CTRL_RST;
			start_reg <= 1'b0;
			stat_reg <= '0;
			merr_reg <= '0;
		end else begin
			ctrl_reg <= ctrl_next;
			start_reg <= start_next;
			stat_reg <= stat_next;
			merr_reg <= merr_next;
		end
	end

	// read mux; unmapped offsets answer with zero
	always_comb begin
		ack_next = req;
		rdat_next = 32'h0;
		if (req && !wb_we_i) begin
			unique case (ofs)
				MBC_CTRL_OFS: rdat_next = 32'(ctrl_reg);
				MBC_STAT_OFS: rdat_next = 32'(stat_reg) | (32'(busy) << MBC_ST_BUSY);
				MBC_MASK_OFS: rdat_next = 32'(mask_q);
				MBC_LOW_OFS: rdat_next = 32'(low_q);
				MBC_HIGH_OFS: rdat_next = 32'(high_q);
				MBC_ARR_OFS: rdat_next = 32'(arr_q);
				MBC_BG_OFS: rdat_next = 32'(bg_q);
				MBC_FAIL_OFS: rdat_next = 32'(fail_addr);
				MBC_MERR_OFS: rdat_next = 32'(merr_reg);
				// build-time parameters
				MBC_CFG0_OFS: rdat_next = {5'h0,
					flop_parity_param, reset_scope_param,
					6'(ERW), 4'(ARW), 9'(DW), 6'(AW)};
				MBC_CFG1_OFS: rdat_next = 32'(6'(program_size_param));
				default: rdat_next = 32'h0;
			endcase
		end
	end

	// ack one cycle after the strobe, dropped the cycle after
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0;
		end else begin
			ack_reg <= ack_next;
			rdat_reg <= rdat_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;

	// memory side drive
	assign test_req_out = mem_req;
	assign test_we_out = mem_we;
	assign test_address_out = mem_addr;
	assign test_write_data_out = mem_wdata;
	assign array_select_out = {arr_q[ARW-1 -: MBC_PLU_BITS], arr_q[ASW-1:0]};

	// functional path kept off the array for the whole run
	assign func_block_out = busy || ctrl_reg[MBC_CTRL_OFFL];
	// level interrupt, masked bits stay flags only
	assign irq_out = |(stat_reg & mask_q);

endmodule : mbc_top

// ---- memory_bist_controller_tb_top.sv ----
`timescale 1ns/1ps
module memory_bist_controller_tb_top import mbc_pkg::*;;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [31:0] wb_adr_i = '0, wb_dat_i = '0, wb_dat_o;
	logic [3:0] wb_sel_i = 4'hF;
	logic wb_ack_o, req, we, func_block_out, irq_out, fault_en = 1'b0;
	logic [3:0] addr, memory_error_in = 4'h0;
	logic [7:0] wdata, rdata;
	logic [5:0] array_select_out;
	logic [7:0] saved [16];
	int failures = 0;
	int compares = 0;
	localparam logic [31:0] CFG0_EXP = 32'h0200_0000 | (32'h4 << 19) | (32'h6 << 15) | (32'h8 << 6) | 32'h4;

	always #2 clk_sys = ~clk_sys;

	mbc_top #(.test_addr_width_param(4), .test_data_width_param(8)) i_dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .test_req_out(req), .test_we_out(we),
		.test_address_out(addr), .test_write_data_out(wdata), .test_read_data_in(rdata),
		.array_select_out(array_select_out), .memory_error_in(memory_error_in),
		.func_block_out(func_block_out), .irq_out(irq_out));

	mbc_mem_model #(.AW(4), .DW(8)) i_mem (
		.clk_sys(clk_sys), .test_req_out(req), .test_we_out(we), .test_address_out(addr),
		.test_write_data_out(wdata), .test_read_data_in(rdata), .fault_en(fault_en),
		.fault_addr(4'h5));

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// classic cycle: hold everything until ack is sampled, then release
	task automatic wb_cycle(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		@(posedge clk_sys);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		if (n >= 50) begin
			failures++;
			report_and_stop();
		end
	endtask : wb_cycle

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		wb_cycle(1'b1, a, d, r);
	endtask : wr

	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] r;
		wb_cycle(1'b0, a, 32'h0, r);
		chk(r, e);
	endtask : rd

	// let registered flags settle before looking at them
	task automatic settle();
		repeat (2) @(posedge clk_sys);
		#1;
	endtask : settle

	// poll the done flag; a run of 16 entries needs a few hundred cycles
	task automatic wait_done();
		logic [31:0] s;
		int n;
		s = '0;
		n = 0;
		while (s[MBC_ST_DONE] !== 1'b1 && n < 300) begin
			wb_cycle(1'b0, MBC_STAT_OFS, 32'h0, s);
			n++;
		end
		if (n >= 300) begin
			failures++;
			report_and_stop();
		end
	endtask : wait_done

	initial begin
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		// reset values, map, read-only and unmapped places
		rd(MBC_CTRL_OFS, 32'h0);
		rd(MBC_MASK_OFS, 32'h0);
		rd(MBC_HIGH_OFS, 32'hF);
		rd(MBC_CFG0_OFS, CFG0_EXP);
		wr(MBC_CFG1_OFS, 32'h0);
		rd(MBC_CFG1_OFS, 32'h6);
		wr(32'h100, 32'hFFFFFFFF);
		rd(32'h100, 32'h0);
		wr(MBC_BG_OFS, 32'h5A);
		rd(32'h1000 | MBC_BG_OFS, 32'h5A);
		wr(MBC_ARR_OFS, 32'h2D);
		rd(MBC_ARR_OFS, 32'h2D);
		chk(32'(array_select_out), 32'h2D);
		$display("test registers done");
		// clean run, events masked: flag only
		wr(MBC_CTRL_OFS, 32'h3);
		chk(32'(func_block_out), 32'h1);
		wait_done();
		rd(MBC_STAT_OFS, 32'h1);
		chk(32'(irq_out), 32'h0);
		for (int i = 0; i < 16; i++) begin
			chk(32'(i_mem.wr_cnt[i]), 32'h5);
			chk(32'(i_mem.mem[i]), 32'h5A);
		end
		rd(MBC_MERR_OFS, 32'h0);
		wr(MBC_MASK_OFS, 32'h1);
		settle();
		chk(32'(irq_out), 32'h1);
		wr(MBC_STAT_OFS, 32'h1);
		settle();
		chk(32'(irq_out), 32'h0);
		wr(MBC_CTRL_OFS, 32'h0);
		settle();
		chk(32'(func_block_out), 32'h0);
		$display("test clean run done");
		// faulty entry and error input during the run, old contents kept aside
		wr(MBC_BG_OFS, 32'hC3);
		for (int i = 0; i < 16; i++) begin
			saved[i] = i_mem.mem[i];
		end
		wr(MBC_MASK_OFS, 32'h2);
		fault_en <= 1'b1;
		wr(MBC_CTRL_OFS, 32'h3);
		memory_error_in <= 4'h2;
		wait_done();
		memory_error_in <= 4'h0;
		fault_en <= 1'b0;
		rd(MBC_STAT_OFS, 32'h3);
		chk(32'(irq_out), 32'h1);
		rd(MBC_FAIL_OFS, 32'h5);
		rd(MBC_MERR_OFS, 32'h2);
		wr(MBC_MERR_OFS, 32'h0);
		rd(MBC_MERR_OFS, 32'h0);
		wr(MBC_STAT_OFS, 32'h3);
		settle();
		chk(32'(irq_out), 32'h0);
		wr(MBC_CTRL_OFS, 32'h0);
		for (int i = 0; i < 16; i++) begin
			chk(32'(i_mem.mem[i]), 32'hC3);
			i_mem.mem[i] = saved[i];
		end
		$display("test error run done");
		// stop on error: run ends at the faulty entry of the first read element
		fault_en <= 1'b1;
		wr(MBC_CTRL_OFS, 32'h7);
		wait_done();
		fault_en <= 1'b0;
		rd(MBC_STAT_OFS, 32'h3);
		chk(32'(i_mem.mem[4]), 32'h3C);
		chk(32'(i_mem.mem[6]), 32'hC3);
		chk(32'(i_mem.wr_cnt[5]), 32'hB);
		wr(MBC_STAT_OFS, 32'h3);
		wr(MBC_CTRL_OFS, 32'h0);
		$display("test stop on error done");
		report_and_stop();
	end
endmodule : memory_bist_controller_tb_top
